// ==== rtl/sadc_pkg.sv ====
package sadc_pkg;

    // =====================================================
    // Register map (byte addresses)
    localparam logic [11:0] SADC_OFS_IN_A   = 12'h000;
    localparam logic [11:0] SADC_OFS_IN_B   = 12'h004;
    localparam logic [11:0] SADC_OFS_STATUS = 12'h008;

    // =====================================================
    // Widths and counts
    localparam int          SADC_RES_BITS  = 12;
    localparam int          SADC_CFG_BITS  = 4;
    localparam logic [3:0]  SADC_CFG_LAST  = 4'h3;
    localparam logic [3:0]  SADC_MSB_IDX   = 4'hb;
    localparam logic [3:0]  SADC_LSB_START = 4'h1;

    // =====================================================
    // Configuration word fields, in arrival order
    localparam int SADC_CFG_SINGLE = 3;
    localparam int SADC_CFG_ODD    = 2;
    localparam int SADC_CFG_ORDER  = 1;
    localparam int SADC_CFG_PWR    = 0;

    // =====================================================
    // Status register fields
    localparam int SADC_ST_RESULT = 0;
    localparam int SADC_ST_CFG    = 12;
    localparam int SADC_ST_SHDN   = 16;
    localparam int SADC_ST_STATE  = 20;

    // =====================================================
    // Reset values
    localparam logic [11:0] SADC_RST_ANALOG = 12'h000;
    localparam logic [3:0]  SADC_RST_CFG    = 4'h0;
    localparam logic [31:0] SADC_RST_PRDATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_CFG   = 3'b010,
        ST_NULL  = 3'b011,
        ST_MSB   = 3'b100,
        ST_LSB   = 3'b101,
        ST_FILL  = 3'b110
    } sadc_state_type;

endpackage

// ==== rtl/sadc_serial_ctrl.sv ====
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Drive after falling edge, sample on rising
// - Receive configuration fully, then drive result
// - Exchange starts only when select falls
// - Leading zeros ignored; first one starts
// - Exactly four configuration bits follow start
// - Input ignored afterwards until next select
// - One null bit, then result MSB first
// - Each bit sent as its step resolves
// - Select high resets the serial interface
// - Single-ended: odd bit picks input
// - Differential: sign bit picks polarity
// - Order one: MSB first, then zeros
// - Order zero: MSB first, then LSB first
// - Power bit zero means shutdown
// - Shutdown: twelve ones, then zeros
// - Shutdown ends with output driven low until select rises
// - Shutdown holds until next select cycle
// - No warm-up after shutdown
// - Result is unipolar straight binary
module sadc_serial_ctrl
    import sadc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sel_n,
    input  wire logic        shift_clk,
    input  wire logic        data_in,
    output logic             data_out,
    output logic             data_out_oe_n
);

    // =====================================================
    // State
    typedef struct packed {
        logic                 sel_m;
        logic                 sel_s;
        logic                 clk_m;
        logic                 clk_s;
        logic                 clk_d;
        logic                 din_m;
        logic                 din_s;
        sadc_state_type       state;
        logic [3:0]           cfg;
        logic [3:0]           cnt;
        logic [11:0]          target;
        logic [11:0]          approx;
        logic                 shutdown;
        logic                 dout;
        logic                 dout_oe_n;
        logic [11:0]          analog_in_a;
        logic [11:0]          analog_in_b;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } sadc_regs_type;

    sadc_regs_type s_r;
    sadc_regs_type s_nxt;

    logic clk_rise;
    logic clk_fall;
    logic sel_high;

    // =====================================================
    // Functions
    function automatic logic [1:0] reg_index(input logic [11:0] addr);
        case (addr)
            SADC_OFS_IN_A:   reg_index = 2'd0;
            SADC_OFS_IN_B:   reg_index = 2'd1;
            SADC_OFS_STATUS: reg_index = 2'd2;
            default:         reg_index = 2'd3;
        endcase
    endfunction

    // Negative differential inputs clip to code zero
    function automatic logic [11:0] code_of(input logic [3:0]  cfg,
                                            input logic [11:0] a,
                                            input logic [11:0] b);
        logic [11:0] pos;
        logic [11:0] neg;
        pos = cfg[SADC_CFG_ODD] ? b : a;
        neg = cfg[SADC_CFG_ODD] ? a : b;
        if (cfg[SADC_CFG_SINGLE]) begin
            code_of = pos;
        end else if (pos > neg) begin
            code_of = pos - neg;
        end else begin
            code_of = 12'h000;
        end
    endfunction

    assign sel_high = s_r.sel_s;
    assign clk_rise = s_r.clk_s & ~s_r.clk_d;
    assign clk_fall = ~s_r.clk_s & s_r.clk_d;

    // =====================================================
    // Next state
    always_comb begin
        logic [11:0] trial;
        logic        bit_v;
        logic [3:0]  word;
        trial = 12'h000;
        bit_v = 1'b0;
        word  = 4'h0;
        s_nxt = s_r;

        // Link pins pass two flops before use
        s_nxt.sel_m = sel_n;
        s_nxt.sel_s = s_r.sel_m;
        s_nxt.clk_m = shift_clk;
        s_nxt.clk_s = s_r.clk_m;
        s_nxt.clk_d = s_r.clk_s;
        s_nxt.din_m = data_in;
        s_nxt.din_s = s_r.din_m;

        if (sel_high) begin
            s_nxt.state     = ST_IDLE;
            s_nxt.dout      = 1'b0;
            s_nxt.dout_oe_n = 1'b1;
            s_nxt.cnt       = 4'h0;
        end else begin
            case (s_r.state)
                ST_IDLE: begin
                    // New select cycle wakes the converter at once
                    s_nxt.shutdown = 1'b0;
                    s_nxt.state    = ST_START;
                end
                ST_START: begin
                    if (clk_rise && s_r.din_s) begin
                        s_nxt.state = ST_CFG;
                        s_nxt.cnt   = 4'h0;
                    end
                end
                ST_CFG: begin
                    if (clk_rise) begin
                        word      = {s_r.cfg[2:0], s_r.din_s};
                        s_nxt.cfg = word;
                        s_nxt.cnt = s_r.cnt + 4'h1;
                        if (s_r.cnt == SADC_CFG_LAST) begin
                            s_nxt.state    = ST_NULL;
                            s_nxt.shutdown = ~word[SADC_CFG_PWR];
                            s_nxt.target   = code_of(word, s_r.analog_in_a,
                                                     s_r.analog_in_b);
                            s_nxt.approx   = 12'h000;
                        end
                    end
                end
                ST_NULL: begin
                    if (clk_fall) begin
                        s_nxt.dout      = 1'b0;
                        s_nxt.dout_oe_n = 1'b0;
                        s_nxt.cnt       = SADC_MSB_IDX;
                        s_nxt.state     = ST_MSB;
                    end
                end
                ST_MSB: begin
                    if (clk_fall) begin
                        // One approximation step per shift clock
                        trial          = s_r.approx;
                        trial[s_r.cnt] = 1'b1;
                        bit_v          = s_r.shutdown | (trial <= s_r.target);
                        s_nxt.dout     = bit_v;
                        if (bit_v && !s_r.shutdown) begin
                            s_nxt.approx = trial;
                        end
                        s_nxt.cnt = s_r.cnt - 4'h1;
                        if (s_r.cnt == 4'h0) begin
                            if (s_r.cfg[SADC_CFG_ORDER] || s_r.shutdown) begin
                                s_nxt.state = ST_FILL;
                            end else begin
                                s_nxt.state = ST_LSB;
                                s_nxt.cnt   = SADC_LSB_START;
                            end
                        end
                    end
                end
                ST_LSB: begin
                    // Bit zero is shared by both halves of the frame
                    if (clk_fall) begin
                        s_nxt.dout = s_r.approx[s_r.cnt];
                        s_nxt.cnt  = s_r.cnt + 4'h1;
                        if (s_r.cnt == SADC_MSB_IDX) begin
                            s_nxt.state = ST_FILL;
                        end
                    end
                end
                ST_FILL: begin
                    if (clk_fall) begin
                        s_nxt.dout = 1'b0;
                    end
                end
                default: begin
                    s_nxt.state = ST_IDLE;
                end
            endcase
        end

        // APB: answer registered in setup, given in access with no wait
        // A status read during a frame is only a snapshot of a moving state
        s_nxt.pready  = psel & ~penable;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
            s_nxt.prdata  = SADC_RST_PRDATA;
            s_nxt.pslverr = (reg_index(paddr) == 2'd3);
            case (reg_index(paddr))
                2'd0: s_nxt.prdata[11:0] = s_r.analog_in_a;
                2'd1: s_nxt.prdata[11:0] = s_r.analog_in_b;
                2'd2: begin
                    s_nxt.prdata[SADC_ST_RESULT +: 12] = s_r.approx;
                    s_nxt.prdata[SADC_ST_CFG +: 4]     = s_r.cfg;
                    s_nxt.prdata[SADC_ST_SHDN]         = s_r.shutdown;
                    s_nxt.prdata[SADC_ST_STATE +: 3]   = s_r.state;
                end
                default: s_nxt.prdata = SADC_RST_PRDATA;
            endcase
        end
        // Inputs are sampled at configuration, so a write mid-frame is safe
        if (psel && penable && pwrite && s_r.pready) begin
            case (reg_index(paddr))
                2'd0:    s_nxt.analog_in_a = pwdata[11:0];
                2'd1:    s_nxt.analog_in_b = pwdata[11:0];
                default: s_nxt.analog_in_a = s_nxt.analog_in_a;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r             <= '0;
            s_r.sel_m       <= 1'b1;
            s_r.sel_s       <= 1'b1;
            s_r.state       <= ST_IDLE;
            s_r.cfg         <= SADC_RST_CFG;
            s_r.dout_oe_n   <= 1'b1;
            s_r.analog_in_a <= SADC_RST_ANALOG;
            s_r.analog_in_b <= SADC_RST_ANALOG;
            s_r.prdata      <= SADC_RST_PRDATA;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata        = s_r.prdata;
    assign pready        = s_r.pready;
    assign pslverr       = s_r.pslverr;
    assign data_out      = s_r.dout;
    assign data_out_oe_n = s_r.dout_oe_n;

    // =====================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_live_fall;
        !sel_high && clk_fall;
    endsequence

    sequence seq_last_cfg;
        s_r.state == ST_CFG && clk_rise && !sel_high && s_r.cnt == SADC_CFG_LAST;
    endsequence

    chk_select_releases: assert property (sel_high |=> s_r.state == ST_IDLE && data_out_oe_n)
        else $error("select high did not reset the link");
    chk_zero_ignored: assert property (
        s_r.state == ST_START && clk_rise && !s_r.din_s && !sel_high |=> s_r.state == ST_START)
        else $error("leading zero taken as start");
    chk_cfg_four_bits: assert property (seq_last_cfg |=> s_r.state == ST_NULL)
        else $error("config word not closed after four bits");
    chk_cfg_frozen: assert property (
        s_r.state inside {ST_NULL, ST_MSB, ST_LSB, ST_FILL} && !sel_high |=> $stable(s_r.cfg))
        else $error("config changed after capture");
    chk_null_then_drive: assert property (
        s_r.state == ST_NULL ##0 seq_live_fall |=> !data_out && !data_out_oe_n ##0
        s_r.state == ST_MSB && s_r.cnt == SADC_MSB_IDX)
        else $error("null bit not driven");
    chk_shutdown_ones: assert property (
        s_r.state == ST_MSB && s_r.shutdown ##0 seq_live_fall |=> data_out)
        else $error("shutdown frame bit not one");
    chk_fill_zero: assert property (s_r.state == ST_FILL ##0 seq_live_fall |=> !data_out)
        else $error("fill bit not zero");
    chk_lsb_follows: assert property (
        s_r.state == ST_MSB && s_r.cnt == 4'h0 && !s_r.cfg[SADC_CFG_ORDER] && !s_r.shutdown
        ##0 seq_live_fall |=> s_r.state == ST_LSB ##0 data_out == s_r.approx[0])
        else $error("reversed half did not follow");
    chk_quiet_until_null: assert property (
        s_r.state inside {ST_IDLE, ST_START, ST_CFG, ST_NULL} |-> data_out_oe_n)
        else $error("output driven before null bit");

    // =====================================================
    // Frame ends, power and bus answer
    sequence seq_last_msb;
        s_r.state == ST_MSB && s_r.cnt == 4'h0 ##0 seq_live_fall;
    endsequence

    chk_start_taken: assert property (
        s_r.state == ST_START && clk_rise && s_r.din_s && !sel_high |=>
        s_r.state == ST_CFG && s_r.cnt == 4'h0)
        else $error("start bit not taken");
    chk_power_flag: assert property (
        seq_last_cfg |=> s_r.shutdown == !s_r.cfg[SADC_CFG_PWR])
        else $error("power bit not applied");
    chk_wake_on_select: assert property (
        s_r.state == ST_IDLE && !sel_high |=> !s_r.shutdown && s_r.state == ST_START)
        else $error("select fall did not wake the link");
    chk_change_on_fall: assert property (!sel_high && !clk_fall |=> $stable(data_out))
        else $error("output changed without a falling edge");
    chk_shutdown_fill: assert property (
        s_r.shutdown ##0 seq_last_msb |=> s_r.state == ST_FILL)
        else $error("shutdown frame not closed after twelve bits");
    chk_order_fill: assert property (
        s_r.cfg[SADC_CFG_ORDER] ##0 seq_last_msb |=> s_r.state == ST_FILL)
        else $error("ordered frame not filled with zeros");
    chk_lsb_to_fill: assert property (
        s_r.state == ST_LSB && s_r.cnt == SADC_MSB_IDX ##0 seq_live_fall |=> s_r.state == ST_FILL)
        else $error("reversed half overran");
    chk_result_settled: assert property (
        s_r.state inside {ST_LSB, ST_FILL} && !s_r.shutdown |-> s_r.approx == s_r.target)
        else $error("approximation did not reach the input code");
    chk_null_entry: assert property (
        $fell(data_out_oe_n) |-> $past(s_r.state) == ST_NULL)
        else $error("output enabled outside the null bit");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held past one cycle");

endmodule

`default_nettype wire

// ==== sim/sadc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module sadc_host_model (
    input  wire logic pclk,
    output var  logic sel_n,
    output var  logic shift_clk,
    output var  logic data_in,
    input  wire logic data_out,
    input  wire logic data_out_oe_n
);
    // =====================================================
    // Link clock stands still low outside a frame, except for the pre pulses before select falls
    initial begin
        sel_n = 1'b1;
        shift_clk = 1'b0;
        data_in = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One shift clock of 400 ns; the output is read after the rise
    task automatic pulse(input logic b, output logic q, output logic oe);
        data_in <= b;
        wait_clk(4);
        shift_clk <= 1'b1;
        @(negedge pclk);
        // A released line reads as one, since data_out is held low whenever the output is released
        q = data_out_oe_n ? ~data_out : data_out;
        oe = data_out_oe_n;
        wait_clk(4);
        shift_clk <= 1'b0;
    endtask

    task automatic frame(input int pre, input int lead, input logic [3:0] cfg, input int n,
                         output logic [31:0] got, output int oe_err);
        logic q;
        logic oe;
        got = '0;
        oe_err = 0;
        for (int i = 0; i < pre; i++) begin
            pulse(1'b1, q, oe);
        end
        wait_clk(4);
        sel_n <= 1'b0;
        wait_clk(4);
        for (int i = 0; i < lead + 5; i++) begin
            pulse((i < lead) ? 1'b0 : ((i == lead) ? 1'b1 : cfg[lead + 4 - i]), q, oe);
            if (oe !== 1'b1) oe_err++;
        end
        // Three-wire host echoes the shared line; with pre set a four-wire host toggles it
        for (int i = 0; i < n; i++) begin
            pulse((pre > 0) ? i[0] : q, q, oe);
            got = {got[30:0], q};
            if (oe !== 1'b0) oe_err++;
        end
        wait_clk(4);
        sel_n <= 1'b1;
        wait_clk(4);
        if (data_out_oe_n !== 1'b1) oe_err++;
    endtask
endmodule

`default_nettype wire

// ==== sim/serial_adc_control_interface_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module serial_adc_control_interface_bench;
    import sadc_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        sel_n, shift_clk, data_in, data_out, data_out_oe_n;
    int          fail_count, tests_run, cycles;

    sadc_serial_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sel_n(sel_n), .shift_clk(shift_clk), .data_in(data_in),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n));
    sadc_host_model u_host (.pclk(pclk), .sel_n(sel_n), .shift_clk(shift_clk),
        .data_in(data_in), .data_out(data_out), .data_out_oe_n(data_out_oe_n));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;

    // =====================================================
    // Reporting
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            results();
        end
    end

    // =====================================================
    // APB master: waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask,
                          input logic experr);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0000_0000, rd, e);
        chk(rd & mask, exp & mask, "read data");
        chk({31'h0, e}, {31'h0, experr}, "slave error");
    endtask

    // =====================================================
    // Expected values
    function automatic logic [11:0] exp_res(logic [11:0] a, logic [11:0] b, logic [3:0] cfg);
        if (cfg[3]) return cfg[2] ? b : a;
        if (!cfg[2]) return (a > b) ? a - b : 12'h000;
        return (b > a) ? b - a : 12'h000;
    endfunction

    function automatic logic [31:0] exp_stream(logic [11:0] r, logic [3:0] cfg, int n);
        logic [31:0] s;
        logic b;
        s = '0;
        for (int i = 0; i < n; i++) begin
            if (i == 0) b = 1'b0;
            else if (i <= 12) b = cfg[0] ? r[12 - i] : 1'b1;
            else if (i <= 23 && !cfg[1] && cfg[0]) b = r[i - 12];
            else b = 1'b0;
            s = {s[30:0], b};
        end
        return s;
    endfunction

    // One exchange, judged on the wire and in the status register
    task automatic conv(input int pre, input int lead, input logic [11:0] a, input logic [11:0] b,
                        input logic [3:0] cfg, input int n);
        logic [31:0] got;
        int          oe_err;
        logic [11:0] r;
        wr(SADC_OFS_IN_A, {20'h0, a});
        wr(SADC_OFS_IN_B, {20'h0, b});
        r = exp_res(a, b, cfg);
        u_host.frame(pre, lead, cfg, n, got, oe_err);
        chk(got, exp_stream(r, cfg, n), "serial stream");
        chk(32'(oe_err), 32'h0, "output enable");
        rd_chk(SADC_OFS_STATUS, {9'h0, 3'h0, 3'h0, ~cfg[0], cfg, r},
               cfg[0] ? 32'hffff_ffff : 32'hffff_f000, 1'b0);
    endtask

    // =====================================================
    // Scenarios
    task automatic t_regs;
        rd_chk(SADC_OFS_IN_A, {20'h0, SADC_RST_ANALOG}, 32'hffff_ffff, 1'b0);
        rd_chk(SADC_OFS_STATUS, 32'h0000_0000, 32'hffff_ffff, 1'b0);
        wr(SADC_OFS_IN_B, 32'hffff_f123);
        rd_chk(SADC_OFS_IN_B, 32'h0000_0123, 32'hffff_ffff, 1'b0);
        wr(SADC_OFS_STATUS, 32'hffff_ffff);
        rd_chk(SADC_OFS_STATUS, 32'h0000_0000, 32'hffff_ffff, 1'b0);
        rd_chk(12'h00c, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    endtask

    task automatic t_mux;
        for (int k = 0; k < 4; k++) begin
            conv(0, 0, 12'h9a5, 12'h3c2, {k[1], k[0], 2'b11}, 20);
        end
        conv(0, 0, 12'h123, 12'hfff, 4'b0111, 20);
    endtask

    task automatic t_order_lead;
        conv(0, 3, 12'h801, 12'h000, 4'b1001, 30);
        conv(0, 1, 12'hfff, 12'h000, 4'b1001, 26);
        conv(0, 6, 12'h5a3, 12'h000, 4'b1011, 13);
    endtask

    task automatic t_ignore;
        conv(3, 0, 12'h000, 12'h555, 4'b1011, 20);
    endtask

    task automatic t_shutdown;
        conv(0, 0, 12'h3c3, 12'h000, 4'b1010, 20);
        conv(0, 0, 12'h3c3, 12'h000, 4'b1011, 20);
        conv(0, 0, 12'h3c3, 12'h000, 4'b1000, 20);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_mux();
        t_order_lead();
        t_ignore();
        t_shutdown();
        results();
    end
endmodule

`default_nettype wire
